// ### design/arc_pkg.sv
package arc_pkg;

    // ----------------------------------------
    // Refresh control register bit positions
    // ----------------------------------------
    localparam int CTRL_SELF_REFRESH = 7;
    localparam int CTRL_PSRAM_EN     = 6;
    localparam int CTRL_DRAM_EN      = 5;
    localparam int CTRL_STROBE_MODE  = 4;
    localparam int CTRL_COL_WIDTH    = 3;
    localparam int CTRL_REFRESH_INDICATOR_PIN_PIN_EN  = 2;
    localparam int CTRL_RESERVED     = 1;
    localparam int CTRL_CYCLE_EN     = 0;

    // ----------------------------------------
    // Timer control/status bit positions
    // ----------------------------------------
    localparam int TMCSR_CMF     = 7;
    localparam int TMCSR_COMPARE_IRQ_ENABLE    = 6;
    localparam int TMCSR_CKS_HI  = 5;
    localparam int TMCSR_CKS_LO  = 3;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [7:0] CTRL_RESET    = 8'h02;
    localparam logic [7:0] TMCSR_RESET   = 8'h07;
    localparam logic [7:0] TMCSR_RO_ONES = 8'h07;
    localparam logic [7:0] CONST_RESET   = 8'hFF;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [2:0] CKS_OFF       = 3'h0;

    // Prescaler width: largest divider is 4096
    localparam int PRESC_W = 12;

    typedef enum logic [1:0] {CYC_IDLE, CYC_T1, CYC_T2, CYC_T3} arc_cyc_st_t;
    typedef enum logic [1:0] {REF_FIRST, REF_PEND, REF_BUS, REF_BUSY} arc_ref_st_t;
    typedef enum logic [1:0] {SR_OFF, SR_CAS, SR_BOTH} arc_sr_st_t;
    typedef enum logic [2:0] {OWN_NONE, OWN_EXT, OWN_REF, OWN_DMA, OWN_CPU} arc_own_t;

    // Low-bit mask of the prescaler for each divider code
    function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] cks);
        logic [PRESC_W-1:0] m;
        m = '0;
        unique case (cks)
            3'h0: m = 12'h0000;
            3'h1: m = 12'h0001;
            3'h2: m = 12'h0007;
            3'h3: m = 12'h001F;
            3'h4: m = 12'h007F;
            3'h5: m = 12'h01FF;
            3'h6: m = 12'h07FF;
            3'h7: m = 12'h0FFF;
        endcase
        return m;
    endfunction

endpackage

// ### design/arc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module arc_prescaler
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       clear_i,
    input  wire logic [2:0] cks_i,
    output logic            tick_o
);

    logic [arc_pkg::PRESC_W-1:0] presc_r;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || clear_i)
            presc_r <= '0;
        else
            presc_r <= presc_r + 12'h001;
    end

    // Code 0 stops the counter input altogether
    assign tick_o = (cks_i != arc_pkg::CKS_OFF) &&
                    ((presc_r & arc_pkg::div_mask(cks_i)) == arc_pkg::div_mask(cks_i));

endmodule
`default_nettype wire

// ### design/arc_addr_mux.sv
`timescale 1ns/1ps
`default_nettype none
module arc_addr_mux
(
    input  wire logic [23:0] addr_i,
    input  wire logic        col_phase_i,
    input  wire logic        col9_i,
    output logic      [23:0] addr_o
);

    always_comb
    begin
        addr_o = addr_i;
        if (col_phase_i)
        begin
            addr_o[7:1] = addr_i[16:10];
            if (col9_i)
            begin
                addr_o[9] = addr_i[18];
                addr_o[8] = addr_i[17];
            end
            else
            begin
                addr_o[9] = addr_i[9];
                addr_o[8] = addr_i[9];
            end
        end
    end

endmodule
`default_nettype wire

// ### design/arc_refresh_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module arc_refresh_ctrl
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        standby_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        ctrl_wr_i,
    input  wire logic        tmcsr_wr_i,
    input  wire logic        tmcsr_rd_i,
    input  wire logic        cnt_wr_i,
    input  wire logic        const_wr_i,
    output logic      [7:0]  refresh_control_reg_o,
    output logic      [7:0]  refresh_timer_ctrl_status_o,
    output logic      [7:0]  refresh_timer_counter_o,
    output logic      [7:0]  refresh_timer_constant_o,
    output logic             compare_match_interrupt_o,
    input  wire logic        three_state_access_bit_i,
    input  wire logic        wait_req_i,
    input  wire logic        ext_req_i,
    input  wire logic        dma_req_i,
    input  wire logic        cpu_req_i,
    output logic             grant_ext_o,
    output logic             grant_refresh_o,
    output logic             grant_dma_o,
    output logic             grant_cpu_o,
    input  wire logic        acc_start_i,
    input  wire logic        acc_write_i,
    input  wire logic        acc_upper_i,
    input  wire logic        acc_lower_i,
    input  wire logic [23:0] acc_addr_i,
    output logic             acc_done_o,
    output logic      [23:0] addr_o,
    output logic             area_chip_select_n_o,
    output logic             upper_write_strobe_n_o,
    output logic             lower_write_strobe_n_o,
    output logic             read_strobe_n_o,
    output logic             refresh_indicator_n_o
);

    // ----------------------------------------
    // Registers and mode decode
    // ----------------------------------------
    logic [7:0] ctrl_r;
    logic       cmf_r;
    logic       compare_irq_enable_r;
    logic [2:0] cks_r;
    logic [7:0] cnt_r;
    logic [7:0] const_r;
    logic       cmf_armed_r;
    logic       tick;
    logic       match;
    logic       mem_en;
    logic       dram_mode;
    logic       psram_mode;
    logic       ref_req;

    arc_pkg::arc_cyc_st_t cyc_r;
    arc_pkg::arc_ref_st_t ref_r;
    arc_pkg::arc_sr_st_t  sr_r;
    arc_pkg::arc_own_t    own_r;
    logic                 cyc_is_ref_r;
    logic                 acc_wr_r;
    logic                 acc_up_r;
    logic                 acc_lo_r;
    logic                 stby_d_r;

    assign mem_en     = ctrl_r[arc_pkg::CTRL_PSRAM_EN] | ctrl_r[arc_pkg::CTRL_DRAM_EN];
    assign dram_mode  = ~ctrl_r[arc_pkg::CTRL_PSRAM_EN] & ctrl_r[arc_pkg::CTRL_DRAM_EN];
    assign psram_mode = ctrl_r[arc_pkg::CTRL_PSRAM_EN] & ~ctrl_r[arc_pkg::CTRL_DRAM_EN];

    // Mode and self-refresh bits stay writable so software can leave memory mode
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ctrl_r <= arc_pkg::CTRL_RESET;
        else if (ctrl_wr_i)
        begin
            ctrl_r[7:5] <= wdata_i[7:5];
            if (!mem_en)
            begin
                ctrl_r[4:2] <= wdata_i[4:2];
                ctrl_r[0]   <= wdata_i[0];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            const_r <= arc_pkg::CONST_RESET;
        else if (const_wr_i && !mem_en)
            const_r <= wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            cks_r <= arc_pkg::CKS_OFF;
        else if (tmcsr_wr_i && !mem_en)
            cks_r <= wdata_i[arc_pkg::TMCSR_CKS_HI:arc_pkg::TMCSR_CKS_LO];
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || standby_i || mem_en)
            compare_irq_enable_r <= 1'b0;
        else if (tmcsr_wr_i)
            compare_irq_enable_r <= wdata_i[arc_pkg::TMCSR_COMPARE_IRQ_ENABLE];
    end

    // ----------------------------------------
    // Timer counter and compare flag
    // ----------------------------------------
    arc_prescaler u_presc
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .clear_i   (standby_i),
        .cks_i     (cks_r),
        .tick_o    (tick)
    );

    assign match = tick && (cnt_r == const_r) && !standby_i;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || standby_i)
            cnt_r <= arc_pkg::COUNT_RESET;
        else if (cnt_wr_i && !mem_en)
            cnt_r <= wdata_i;
        else if (match)
            cnt_r <= arc_pkg::COUNT_RESET;
        else if (tick)
            cnt_r <= cnt_r + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || standby_i)
            cmf_armed_r <= 1'b0;
        else if (tmcsr_wr_i)
            cmf_armed_r <= 1'b0;
        else if (tmcsr_rd_i && cmf_r)
            cmf_armed_r <= 1'b1;
    end

    // Setting wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || standby_i)
            cmf_r <= 1'b0;
        else if (match)
            cmf_r <= 1'b1;
        else if (tmcsr_wr_i && !wdata_i[arc_pkg::TMCSR_CMF] && cmf_armed_r)
            cmf_r <= 1'b0;
    end

    assign compare_match_interrupt_o = cmf_r & compare_irq_enable_r;

    // ----------------------------------------
    // Refresh request state
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || standby_i || !(dram_mode || psram_mode))
            ref_r <= arc_pkg::REF_FIRST;
        else
        begin
            unique case (ref_r)
                arc_pkg::REF_FIRST:
                    if (match)
                        ref_r <= arc_pkg::REF_PEND;
                arc_pkg::REF_PEND:
                    if (match && ctrl_r[arc_pkg::CTRL_CYCLE_EN])
                        ref_r <= arc_pkg::REF_BUS;
                arc_pkg::REF_BUS:
                    if (own_r == arc_pkg::OWN_REF && cyc_r == arc_pkg::CYC_IDLE)
                        ref_r <= arc_pkg::REF_BUSY;
                arc_pkg::REF_BUSY:
                    // Matches seen here are simply dropped
                    if (cyc_r == arc_pkg::CYC_T3 && cyc_is_ref_r && !(three_state_access_bit_i && wait_req_i))
                        ref_r <= arc_pkg::REF_PEND;
            endcase
        end
    end

    assign ref_req = (ref_r == arc_pkg::REF_BUS) || (ref_r == arc_pkg::REF_BUSY);

    // ----------------------------------------
    // Bus arbiter
    // ----------------------------------------
    // Owner keeps the bus until its request drops; one idle cycle between owners
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            own_r <= arc_pkg::OWN_NONE;
        else
        begin
            unique case (own_r)
                arc_pkg::OWN_NONE:
                    if (ext_req_i)
                        own_r <= arc_pkg::OWN_EXT;
                    else if (ref_req)
                        own_r <= arc_pkg::OWN_REF;
                    else if (dma_req_i)
                        own_r <= arc_pkg::OWN_DMA;
                    else if (cpu_req_i)
                        own_r <= arc_pkg::OWN_CPU;
                arc_pkg::OWN_EXT:
                    if (!ext_req_i)
                        own_r <= arc_pkg::OWN_NONE;
                arc_pkg::OWN_REF:
                    if (!ref_req)
                        own_r <= arc_pkg::OWN_NONE;
                arc_pkg::OWN_DMA:
                    if (!dma_req_i && cyc_r == arc_pkg::CYC_IDLE)
                        own_r <= arc_pkg::OWN_NONE;
                arc_pkg::OWN_CPU:
                    if (!cpu_req_i && cyc_r == arc_pkg::CYC_IDLE)
                        own_r <= arc_pkg::OWN_NONE;
                default:
                    own_r <= arc_pkg::OWN_NONE;
            endcase
        end
    end

    assign grant_ext_o     = (own_r == arc_pkg::OWN_EXT);
    assign grant_refresh_o = (own_r == arc_pkg::OWN_REF);
    assign grant_dma_o     = (own_r == arc_pkg::OWN_DMA);
    assign grant_cpu_o     = (own_r == arc_pkg::OWN_CPU);

    // ----------------------------------------
    // Three-state cycle engine
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || standby_i)
            cyc_r <= arc_pkg::CYC_IDLE;
        else
        begin
            unique case (cyc_r)
                arc_pkg::CYC_IDLE:
                    if ((ref_r == arc_pkg::REF_BUS && own_r == arc_pkg::OWN_REF) ||
                        (acc_start_i && mem_en && (grant_dma_o || grant_cpu_o)))
                        cyc_r <= arc_pkg::CYC_T1;
                arc_pkg::CYC_T1:
                    cyc_r <= arc_pkg::CYC_T2;
                arc_pkg::CYC_T2:
                    cyc_r <= arc_pkg::CYC_T3;
                arc_pkg::CYC_T3:
                    if (!(three_state_access_bit_i && wait_req_i))
                        cyc_r <= arc_pkg::CYC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cyc_is_ref_r <= 1'b0;
            acc_wr_r     <= 1'b0;
            acc_up_r     <= 1'b0;
            acc_lo_r     <= 1'b0;
        end
        else if (cyc_r == arc_pkg::CYC_IDLE)
        begin
            cyc_is_ref_r <= (ref_r == arc_pkg::REF_BUS && own_r == arc_pkg::OWN_REF);
            acc_wr_r     <= acc_write_i;
            acc_up_r     <= acc_upper_i;
            acc_lo_r     <= acc_lower_i;
        end
    end

    assign acc_done_o = (cyc_r == arc_pkg::CYC_T3) && !cyc_is_ref_r &&
                        !(three_state_access_bit_i && wait_req_i);

    arc_addr_mux u_amux
    (
        .addr_i      (acc_addr_i),
        .col_phase_i (dram_mode && !cyc_is_ref_r &&
                      (cyc_r == arc_pkg::CYC_T2 || cyc_r == arc_pkg::CYC_T3)),
        .col9_i      (ctrl_r[arc_pkg::CTRL_COL_WIDTH]),
        .addr_o      (addr_o)
    );

    // ----------------------------------------
    // Self-refresh around software standby
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            stby_d_r <= 1'b0;
        else
            stby_d_r <= standby_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !standby_i)
            sr_r <= arc_pkg::SR_OFF;
        else if (!stby_d_r && dram_mode && ctrl_r[arc_pkg::CTRL_SELF_REFRESH])
            sr_r <= arc_pkg::SR_CAS;
        else if (sr_r == arc_pkg::SR_CAS)
            sr_r <= arc_pkg::SR_BOTH;
    end

    // ----------------------------------------
    // Strobe mapping
    // ----------------------------------------
    logic busy;
    logic late;
    logic cas;
    logic ras;
    logic two_cas;

    assign busy    = (cyc_r != arc_pkg::CYC_IDLE);
    assign late    = (cyc_r == arc_pkg::CYC_T2) || (cyc_r == arc_pkg::CYC_T3);
    assign two_cas = ctrl_r[arc_pkg::CTRL_STROBE_MODE];
    // Refresh is CAS before RAS; accesses are RAS before CAS
    assign cas = (sr_r != arc_pkg::SR_OFF) || (cyc_is_ref_r ? busy : late);
    assign ras = (sr_r == arc_pkg::SR_BOTH) || (cyc_is_ref_r ? late : busy);

    always_comb
    begin
        area_chip_select_n_o   = 1'b1;
        upper_write_strobe_n_o = 1'b1;
        lower_write_strobe_n_o = 1'b1;
        read_strobe_n_o        = 1'b1;
        if (dram_mode)
        begin
            area_chip_select_n_o = ~ras;
            if (two_cas)
            begin
                upper_write_strobe_n_o = ~(cas && (cyc_is_ref_r || sr_r != arc_pkg::SR_OFF || acc_up_r));
                lower_write_strobe_n_o = ~(cas && (cyc_is_ref_r || sr_r != arc_pkg::SR_OFF || acc_lo_r));
                read_strobe_n_o        = ~(busy && !cyc_is_ref_r && acc_wr_r);
            end
            else
            begin
                read_strobe_n_o        = ~cas;
                upper_write_strobe_n_o = ~(late && !cyc_is_ref_r && acc_wr_r && acc_up_r);
                lower_write_strobe_n_o = ~(late && !cyc_is_ref_r && acc_wr_r && acc_lo_r);
            end
        end
        else if (psram_mode && busy && !cyc_is_ref_r)
        begin
            area_chip_select_n_o   = 1'b0;
            read_strobe_n_o        = ~(late && !acc_wr_r);
            upper_write_strobe_n_o = ~(late && acc_wr_r && acc_up_r);
            lower_write_strobe_n_o = ~(late && acc_wr_r && acc_lo_r);
        end
    end

    assign refresh_indicator_n_o = ~(busy && cyc_is_ref_r && ctrl_r[arc_pkg::CTRL_REFRESH_INDICATOR_PIN_PIN_EN]);

    assign refresh_control_reg_o       = ctrl_r | 8'h02;
    assign refresh_timer_ctrl_status_o = {cmf_r, compare_irq_enable_r, cks_r, 3'h7};
    assign refresh_timer_counter_o     = cnt_r;
    assign refresh_timer_constant_o    = const_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    irq_forced_low_a : assert property (mem_en |=> !compare_match_interrupt_o)
        else $error("timer interrupt in memory mode");
    const_protect_a : assert property (const_wr_i && mem_en |=> $stable(const_r))
        else $error("constant written while protected");
    match_clears_cnt_a : assert property (match && !cnt_wr_i |=> cnt_r == 8'h00 && cmf_r)
        else $error("match did not clear counter");
    first_skip_a : assert property (ref_r == arc_pkg::REF_FIRST && match && dram_mode && !standby_i
                                    |=> ref_r == arc_pkg::REF_PEND && !cyc_is_ref_r)
        else $error("first request not skipped");
    grant_before_ref_a : assert property (cyc_r == arc_pkg::CYC_T1 && cyc_is_ref_r |-> $past(own_r) == arc_pkg::OWN_REF)
        else $error("refresh without bus grant");
    three_states_a : assert property ($rose(cyc_r == arc_pkg::CYC_T1) && !three_state_access_bit_i && !standby_i
                                      |=> cyc_r == arc_pkg::CYC_T2 ##1 cyc_r == arc_pkg::CYC_T3
                                      ##1 cyc_r == arc_pkg::CYC_IDLE)
        else $error("cycle not three states");
    cycle_enable_a : assert property (ref_r == arc_pkg::REF_PEND && !ctrl_r[arc_pkg::CTRL_CYCLE_EN]
                                      |=> ref_r != arc_pkg::REF_BUS)
        else $error("refresh queued while disabled");
    busy_discard_a : assert property (ref_r == arc_pkg::REF_BUSY |=> ref_r != arc_pkg::REF_BUS)
        else $error("request queued during refresh");
    ext_priority_a : assert property (own_r == arc_pkg::OWN_NONE && ext_req_i |=> grant_ext_o)
        else $error("external master lost priority");
    sr_order_a : assert property (sr_r == arc_pkg::SR_CAS && standby_i
                                  |-> area_chip_select_n_o ##1 !area_chip_select_n_o)
        else $error("self refresh order wrong");
    cmf_write_one_a : assert property (cmf_r && tmcsr_wr_i && wdata_i[arc_pkg::TMCSR_CMF] && !standby_i |=> cmf_r)
        else $error("writing one cleared flag");

    refresh_run_c : cover property (ref_r == arc_pkg::REF_BUSY ##1 ref_r == arc_pkg::REF_PEND);
    wait_stretch_c : cover property (cyc_r == arc_pkg::CYC_T3 ##1 cyc_r == arc_pkg::CYC_T3);
    self_refresh_c : cover property (sr_r == arc_pkg::SR_BOTH);
    timer_irq_c : cover property (compare_match_interrupt_o);

endmodule
`default_nettype wire

// ### verif/arc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module arc_mem_model
(
    input  wire logic        clk_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic [23:0] addr_i,
    output logic      [7:0]  ref_cnt_o,
    output logic      [23:0] row_o,
    output logic      [23:0] col_o
);
    logic ras_q = 1'b1;
    logic cas_q = 1'b1;
    initial ref_cnt_o = 8'h00;
    // Strobes sampled on the clock so glitches never count
    always @(posedge clk_i)
    begin
        ras_q <= ras_n_i;
        cas_q <= cas_n_i;
        if (ras_q && !ras_n_i && cas_n_i)
            row_o <= addr_i;
        if (cas_q && !cas_n_i && ras_n_i)
            ref_cnt_o <= ref_cnt_o + 8'h01;
        else if (cas_q && !cas_n_i)
            col_o <= addr_i;
    end
endmodule
`default_nettype wire

// ### verif/area_refresh_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module area_refresh_controller_tb;
    logic        clk_i = 0, sys_rst_i = 1, standby_i = 0, ctrl_wr_i = 0, tmcsr_wr_i = 0, tmcsr_rd_i = 0;
    logic        const_wr_i = 0, cpu_req_i = 0, acc_start_i = 0, acc_write_i = 0, acc_upper_i = 0, ext_req_i = 0;
    logic [7:0]  wdata_i = 8'h00;
    logic [23:0] acc_addr_i = 24'h00_0000;
    logic [7:0]  ctl, tms, cnt, cst, ref_cnt;
    logic        irq, g_ext, g_ref, g_dma, g_cpu, done, cs_n, uw_n, lw_n, rd_n, rf_n;
    logic [23:0] addr, row, col;
    localparam logic [23:0] A = 24'h5A_BCDE;
    int          bad_count = 0, cmp_count = 0, n;
    always #5 clk_i = ~clk_i;
    arc_refresh_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .standby_i(standby_i), .wdata_i(wdata_i),
        .ctrl_wr_i(ctrl_wr_i), .tmcsr_wr_i(tmcsr_wr_i), .tmcsr_rd_i(tmcsr_rd_i), .cnt_wr_i(1'b0),
        .const_wr_i(const_wr_i), .refresh_control_reg_o(ctl), .refresh_timer_ctrl_status_o(tms),
        .refresh_timer_counter_o(cnt), .refresh_timer_constant_o(cst), .compare_match_interrupt_o(irq),
        .three_state_access_bit_i(1'b0), .wait_req_i(1'b0), .ext_req_i(ext_req_i), .dma_req_i(1'b0),
        .cpu_req_i(cpu_req_i), .grant_ext_o(g_ext), .grant_refresh_o(g_ref), .grant_dma_o(g_dma),
        .grant_cpu_o(g_cpu), .acc_start_i(acc_start_i), .acc_write_i(acc_write_i), .acc_upper_i(acc_upper_i),
        .acc_lower_i(1'b0), .acc_addr_i(acc_addr_i), .acc_done_o(done), .addr_o(addr),
        .area_chip_select_n_o(cs_n), .upper_write_strobe_n_o(uw_n), .lower_write_strobe_n_o(lw_n),
        .read_strobe_n_o(rd_n), .refresh_indicator_n_o(rf_n));
    arc_mem_model mem (.clk_i(clk_i), .ras_n_i(cs_n), .cas_n_i(rd_n), .addr_i(addr),
        .ref_cnt_o(ref_cnt), .row_o(row), .col_o(col));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobe mask order: control, ctrl/status, constant, status read
    task automatic wr(input logic [3:0] w, input logic [7:0] d);
        @(posedge clk_i);
        {ctrl_wr_i, tmcsr_wr_i, const_wr_i, tmcsr_rd_i} <= w;
        wdata_i <= d;
        @(posedge clk_i);
        {ctrl_wr_i, tmcsr_wr_i, const_wr_i, tmcsr_rd_i} <= 4'h0;
        #1;
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        bad_count++;
        close_out();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 0;
        @(posedge clk_i);
        #1;
        chk({ctl, tms, cst}, 24'h02_07FF);
        wr(4'h2, 8'h03);
        wr(4'h4, 8'h48);
        for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk_i) #1;
        chk({irq, cnt}, 24'h00_0100);
        repeat (2) @(posedge clk_i) #1;
        chk(cnt, 24'h00_0001);
        wr(4'h4, 8'h40);
        wr(4'h4, 8'h40);
        chk(tms, 24'h00_00C7);
        wr(4'h1, 8'h00);
        wr(4'h4, 8'h48);
        chk({irq, tms}, 24'h00_004F);
        wr(4'h8, 8'h25);
        n = 0;
        chk(ctl, 24'h00_0027);
        wr(4'h2, 8'h10);
        wr(4'h4, 8'h78);
        chk({cst, 1'b0, tms[6:0]}, 24'h00_030F);
        for (n = 4; n < 100 && g_ref !== 1'b1; n++) @(posedge clk_i) #1;
        chk({23'h0, n > 8}, 24'h00_0001);
        // First refresh state: CAS and refresh pin low, RAS still high
        @(posedge clk_i) #1;
        chk({rf_n, rd_n, cs_n}, 24'h00_0001);
        for (n = 0; n < 20 && g_ref !== 1'b0; n++) @(posedge clk_i) #1;
        chk(ref_cnt, 24'h00_0001);
        @(posedge clk_i);
        {cpu_req_i, ext_req_i} <= 2'b11;
        for (n = 0; n < 20 && g_ext !== 1'b1; n++) @(posedge clk_i) #1;
        chk({g_ext, g_ref, g_dma, g_cpu}, 24'h00_0008);
        // A refresh request queues while the external master holds the bus
        @(posedge clk_i);
        ext_req_i <= 0;
        for (n = 0; n < 20 && {g_ref, g_cpu} === 2'b00; n++) @(posedge clk_i) #1;
        chk({g_ref, g_cpu}, 24'h00_0002);
        for (n = 0; n < 100 && g_cpu !== 1'b1; n++) @(posedge clk_i) #1;
        @(posedge clk_i);
        {acc_start_i, acc_write_i, acc_upper_i} <= 3'b111;
        acc_addr_i <= A;
        for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge clk_i) #1;
        chk({uw_n, lw_n}, 24'h00_0001);
        @(posedge clk_i);
        {acc_start_i, cpu_req_i} <= 2'b00;
        @(posedge clk_i) #1;
        chk(row, A);
        chk(col, {A[23:10], A[9], A[9], A[16:10], A[0]});
        wr(4'h8, 8'hA5);
        // Let the queued refresh finish so standby entry starts from idle strobes
        for (n = 0; n < 20 && g_ref !== 1'b1; n++) @(posedge clk_i) #1;
        for (n = 0; n < 20 && g_ref !== 1'b0; n++) @(posedge clk_i) #1;
        @(posedge clk_i);
        standby_i <= 1;
        #1;
        for (n = 0; n < 4 && rd_n !== 1'b0; n++) @(posedge clk_i) #1;
        chk({rd_n, cs_n}, 24'h00_0001);
        @(posedge clk_i) #1;
        chk({rd_n, cs_n}, 24'h00_0000);
        @(posedge clk_i);
        standby_i <= 0;
        @(posedge clk_i) #1;
        chk({rd_n, cs_n}, 24'h00_0003);
        // Leave memory mode, then PSRAM with refresh cycles off
        wr(4'h8, 8'h00);
        wr(4'h8, 8'h44);
        for (n = 0; n < 40 && g_ref !== 1'b1; n++) @(posedge clk_i) #1;
        chk(n[23:0], 24'h00_0028);
        @(posedge clk_i);
        cpu_req_i <= 1;
        for (n = 0; n < 20 && g_cpu !== 1'b1; n++) @(posedge clk_i) #1;
        @(posedge clk_i);
        {acc_start_i, acc_write_i} <= 2'b10;
        for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge clk_i) #1;
        chk({cs_n, rd_n, uw_n}, 24'h00_0001);
        chk(addr, A);
        @(posedge clk_i);
        {acc_start_i, cpu_req_i} <= 2'b00;
        @(posedge clk_i) #1;
        close_out();
    end
endmodule
`default_nettype wire
